// ===== core/pix_if.sv
// Pixel port between graphics accelerator and palette DAC
`timescale 1ns/1ps
`default_nettype none
interface pix_if;
   logic [63:0] pix_data;
   logic        load_enable_n;
   logic        blank_n;

   modport host (
      output pix_data,
      output load_enable_n,
      output blank_n
   );
   modport device (
      input pix_data,
      input load_enable_n,
      input blank_n
   );
endinterface
`default_nettype wire

// ===== core/pix_pkg.sv
// Shared constants and types of the pixel port
package pix_pkg;
   // ==========================================================
   // Widths and depths
   localparam int PORT_W     = 64;
   localparam int WORD_W     = 128;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW    = 4;

   // ==========================================================
   // Modes
   typedef enum logic [1:0] {PW_16, PW_32, PW_64} port_width_e;
   typedef enum logic [1:0] {VIS_4, VIS_8, VIS_16, VIS_32} visual_e;

   // ==========================================================
   // Counts and patterns
   localparam logic [2:0] FLUSH_16    = 3'h5;
   localparam logic [2:0] FLUSH_32    = 3'h3;
   localparam logic [2:0] FLUSH_64    = 3'h2;
   localparam logic [2:0] FLYBACK_PAT = 3'h2;
   localparam logic [2:0] DIV_SEL_MAX = 3'h4;

   // ==========================================================
   // Reset values
   localparam logic [2:0] BLANK_HIST_RST = 3'h7;
   localparam logic       BLANK_N_RST    = 1'h1;
endpackage

// ===== core/pix_port_device.sv
// Pixel port device: gathering, FIFO, unpack, LUT and DAC
//
// Functional notes
// R1 - Upper 32 bits follow lower, same format
// R2 - Planar word: four planes, p0 at top
// R3 - Source avoids planar visual above 135 MHz
// R4 - 16-bit planar: planes 0,1 then 2,3
// R5 - 8-bit indexed: pixel 0 in low byte
// R6 - 16bpp mixing: bit 15 picks bypass
// R7 - No mixing: bypass always, LUT off
// R8 - 16bpp: 5-bit fields, index bits 7:0
// R9 - 32bpp mixing: bit 31 picks bypass
// R10 - 32bpp fields: 10-bit bypass, 8-bit gamma
// R11 - 5-bit gamma value widens to address
// R12 - LUT byte widens to 10-bit DAC
// R13 - 5-bit bypass value repeats into DAC
// R14 - Blank 0,1,0 on video edges: flyback
// R15 - Flyback clears FIFO pointers and cursor
// R16 - Gather 128-bit words, pipelined core write
// R17 - Source adds 5, 3, 2 flush loads
// R18 - Read 32-bit words only while displaying
// R19 - Line length whole multiple per visual
// R20 - Load enable high: port data ignored
// R21 - Blank low turns DAC outputs off
// R22 - Video clock is dot rate divided
// R23 - Pixels leave word in ascending order
// R24 - Each channel indexes its own LUT column
`timescale 1ns/1ps
`default_nettype none
module pix_port_device (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   // Pixel port
   pix_if.device                     px,
   // Configuration
   input  wire pix_pkg::port_width_e port_width,
   input  wire pix_pkg::visual_e     visual,
   input  wire logic                 pixel_mixing,
   input  wire logic                 direct_color,
   input  wire logic [2:0]           video_clock_div_sel,
   input  wire logic                 flyback_ctrl,
   // LUT load
   input  wire logic                 lut_wr,
   input  wire logic [7:0]           lut_wr_addr,
   input  wire logic [23:0]          lut_wr_data,
   // Outputs
   output logic [9:0]                dac_red,
   output logic [9:0]                dac_green,
   output logic [9:0]                dac_blue,
   output logic                      dac_on,
   output logic                      lut_power,
   output logic                      frame_flyback,
   output logic [10:0]               cursor_x,
   output logic                      fifo_overrun
);
   // ==========================================================
   // Load side gathering
   logic [127:0] acc_r, acc_nxt, wr_word_r;
   logic [3:0]   step, slot_sum;
   logic [2:0]   slot_r;
   logic         load, word_done, clr, wr_pend_r;

   // R20 ignore when enable high
   assign load = ~px.load_enable_n;

   always_comb begin
      case (port_width)
         pix_pkg::PW_16: step = 4'h1;
         pix_pkg::PW_32: step = 4'h2;
         default:        step = 4'h4;
      endcase
   end

   assign slot_sum  = {1'b0, slot_r} + step;
   assign word_done = load & slot_sum[3];

   // R1 upper lanes land after lower
   // R4 later loads fill higher halves
   genvar k;
   generate
      for (k = 0; k < 8; k = k + 1) begin : g_slot
         logic [2:0] off;
         assign off = 3'(k) - slot_r;
         always_comb begin
            acc_nxt[k*16 +: 16] = acc_r[k*16 +: 16];
            if (load && ({1'b0, off} < step)) begin
               acc_nxt[k*16 +: 16] = px.pix_data[off[1:0]*16 +: 16];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_r <= '0;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // R16 count 16-bit slots per word
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_r <= '0;
      end else if (clr) begin
         slot_r <= '0;
      end else if (load) begin
         slot_r <= slot_sum[2:0];
      end
   end

   // R16 pipelined core write
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend_r <= 1'b0;
         wr_word_r <= '0;
      end else begin
         wr_pend_r <= word_done & ~clr;
         if (word_done) begin
            wr_word_r <= acc_nxt;
         end
      end
   end

   // ==========================================================
   // FIFO core
   logic [127:0] mem [pix_pkg::FIFO_DEPTH];
   logic [4:0]   wptr_r;
   logic [6:0]   rptr_r;
   logic         empty, full, fetch;

   assign empty = (wptr_r == rptr_r[6:2]);
   assign full  = (wptr_r[3:0] == rptr_r[5:2]) && (wptr_r[4] != rptr_r[6]);

   always_ff @(posedge sys_clk) begin
      if (wr_pend_r && !full) begin
         mem[wptr_r[3:0]] <= wr_word_r;
      end
   end

   // R15 flyback clears pointers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wptr_r <= '0;
      end else if (clr) begin
         wptr_r <= '0;
      end else if (wr_pend_r && !full) begin
         wptr_r <= wptr_r + 5'h1;
      end
   end

   // Sticky; a new loss beats the clear
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fifo_overrun <= 1'b0;
      end else if (wr_pend_r && full) begin
         fifo_overrun <= 1'b1;
      end else if (clr) begin
         fifo_overrun <= 1'b0;
      end
   end

   // ==========================================================
   // Video timing and flyback detection
   logic [3:0] div_cnt_r, div_max;
   logic [2:0] blank_hist_r;
   logic       tick, hit, disp_r;

   // R22 video edge every 1..16 dots
   assign div_max = 4'((5'h1 << ((video_clock_div_sel > pix_pkg::DIV_SEL_MAX) ?
                    pix_pkg::DIV_SEL_MAX : video_clock_div_sel)) - 5'h1);
   assign tick    = (div_cnt_r >= div_max);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= tick ? 4'h0 : div_cnt_r + 4'h1;
      end
   end

   // R14 match 0,1,0 on video edges
   assign hit = tick && ({blank_hist_r[1:0], px.blank_n} == pix_pkg::FLYBACK_PAT);
   assign clr = hit | flyback_ctrl;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         blank_hist_r  <= pix_pkg::BLANK_HIST_RST;
         disp_r        <= 1'b0;
         frame_flyback <= 1'b0;
      end else begin
         frame_flyback <= hit;
         if (tick) begin
            blank_hist_r <= {blank_hist_r[1:0], px.blank_n};
            disp_r       <= px.blank_n;
         end
      end
   end

   // ==========================================================
   // Word readout and pixel serialiser
   logic [31:0] word_r;
   logic        word_ok_r;
   logic [2:0]  idx_r;
   logic [2:0]  last;
   logic        emit;

   always_comb begin
      case (visual)
         pix_pkg::VIS_4:  last = 3'h7;
         pix_pkg::VIS_8:  last = 3'h3;
         pix_pkg::VIS_16: last = 3'h1;
         default:         last = 3'h0;
      endcase
   end

   assign emit  = disp_r & word_ok_r;
   // R18 advance only while displaying; first word waits ready
   assign fetch = ~empty & (~word_ok_r | (emit & (idx_r == last)));

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rptr_r    <= '0;
         word_r    <= '0;
         word_ok_r <= 1'b0;
         idx_r     <= '0;
      end else if (clr) begin
         rptr_r    <= '0;
         word_ok_r <= 1'b0;
         idx_r     <= '0;
      end else if (emit && idx_r != last) begin
         // R23 ascending pixel order
         idx_r <= idx_r + 3'h1;
      end else if (emit || !word_ok_r) begin
         idx_r     <= '0;
         word_ok_r <= fetch;
         if (fetch) begin
            word_r <= mem[rptr_r[5:2]][rptr_r[1:0]*32 +: 32];
            rptr_r <= rptr_r + 7'h1;
         end
      end
   end

   // R15 cursor follows flyback
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cursor_x <= '0;
      end else if (clr) begin
         cursor_x <= '0;
      end else if (emit) begin
         cursor_x <= cursor_x + 11'h1;
      end
   end

   // ==========================================================
   // Pixel decode
   logic [15:0] p16;
   logic [7:0]  idx8;
   logic        byp;
   logic [7:0]  a_r, a_g, a_b;
   logic [9:0]  b_r, b_g, b_b;

   assign p16 = idx_r[0] ? word_r[31:16] : word_r[15:0];

   always_comb begin
      byp  = 1'b0;
      idx8 = 8'h0;
      b_r  = '0;
      b_g  = '0;
      b_b  = '0;
      case (visual)
         // R2 plane 0 is index lsb, p0 at plane top
         pix_pkg::VIS_4: idx8 = {4'h0, word_r[5'd31 - 5'(idx_r)], word_r[5'd23 - 5'(idx_r)],
                                 word_r[5'd15 - 5'(idx_r)], word_r[5'd7 - 5'(idx_r)]};
         // R5 pixel 0 in low byte
         pix_pkg::VIS_8: idx8 = word_r[idx_r[1:0]*8 +: 8];
         pix_pkg::VIS_16: begin
            // R6 R7 bit 15 or no mixing means bypass
            byp  = ~pixel_mixing | p16[15];
            // R8 index in low byte
            idx8 = p16[7:0];
            // R13 5-bit value repeated
            b_r  = {p16[14:10], p16[14:10]};
            b_g  = {p16[9:5], p16[9:5]};
            b_b  = {p16[4:0], p16[4:0]};
         end
         default: begin
            // R9 R7 bit 31 or no mixing means bypass
            byp  = ~pixel_mixing | word_r[31];
            // R10 ten-bit bypass fields
            idx8 = word_r[7:0];
            b_r  = word_r[29:20];
            b_g  = word_r[19:10];
            b_b  = word_r[9:0];
         end
      endcase
      a_r = idx8;
      a_g = idx8;
      a_b = idx8;
      if (direct_color && visual == pix_pkg::VIS_16) begin
         // R11 widen gamma value to address
         a_r = {p16[14:10], p16[14:12]};
         a_g = {p16[9:5], p16[9:7]};
         a_b = {p16[4:0], p16[4:2]};
      end else if (direct_color && visual == pix_pkg::VIS_32) begin
         // R10 eight-bit gamma fields
         a_r = word_r[29:22];
         a_g = word_r[19:12];
         a_b = word_r[9:2];
      end
   end

   // ==========================================================
   // LUT and DAC pipeline
   logic [23:0] lut_mem [256];
   logic [7:0]  s1_a_r, s1_a_g, s1_a_b;
   logic [29:0] s1_b_r, s2_b_r;
   logic [23:0] s2_q_r;
   logic        s1_byp_r, s1_on_r, s2_byp_r, s2_on_r;

   always_ff @(posedge sys_clk) begin
      if (lut_wr) begin
         lut_mem[lut_wr_addr] <= lut_wr_data;
      end
   end

   // R7 LUT powered only when needed
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lut_power <= 1'b0;
      end else begin
         lut_power <= ~(visual[1] & ~pixel_mixing);
      end
   end

   always_ff @(posedge sys_clk) begin
      s1_a_r <= a_r;
      s1_a_g <= a_g;
      s1_a_b <= a_b;
      s1_b_r <= {b_r, b_g, b_b};
      s2_b_r <= s1_b_r;
      // R24 one column per channel
      if (lut_power) begin
         s2_q_r <= {lut_mem[s1_a_r][23:16], lut_mem[s1_a_g][15:8], lut_mem[s1_a_b][7:0]};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_byp_r <= 1'b0;
         s1_on_r  <= 1'b0;
         s2_byp_r <= 1'b0;
         s2_on_r  <= 1'b0;
      end else begin
         s1_byp_r <= byp;
         s1_on_r  <= emit;
         s2_byp_r <= s1_byp_r;
         s2_on_r  <= s1_on_r;
      end
   end

   // R21 blanked pixels drive zero
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_red   <= '0;
         dac_green <= '0;
         dac_blue  <= '0;
         dac_on    <= 1'b0;
      end else begin
         dac_on <= s2_on_r;
         if (!s2_on_r) begin
            dac_red   <= '0;
            dac_green <= '0;
            dac_blue  <= '0;
         end else if (s2_byp_r) begin
            dac_red   <= s2_b_r[29:20];
            dac_green <= s2_b_r[19:10];
            dac_blue  <= s2_b_r[9:0];
         end else begin
            // R12 LUT byte plus its top two bits
            dac_red   <= {s2_q_r[23:16], s2_q_r[23:22]};
            dac_green <= {s2_q_r[15:8], s2_q_r[15:14]};
            dac_blue  <= {s2_q_r[7:0], s2_q_r[7:6]};
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/pix_port_host.sv
// Accelerator end: pixel loads, flush loads, flyback sequence
`timescale 1ns/1ps
`default_nettype none
module pix_port_host (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_b,
   // Pixel port
   pix_if.host                       px,
   // Configuration
   input  wire pix_pkg::port_width_e port_width,
   input  wire logic [2:0]           video_clock_div_sel,
   // User requests
   input  wire logic [63:0]          src_data,
   input  wire logic                 src_valid,
   input  wire logic                 src_blank_n,
   input  wire logic                 flush_req,
   input  wire logic                 flyback_req,
   // Status
   output logic                      busy
);
   typedef enum {HS_IDLE, HS_LOW1, HS_HIGH, HS_LOW2} fly_state_e;

   fly_state_e state_r;
   logic [2:0] flush_cnt_r;
   logic [3:0] div_cnt_r;
   logic [3:0] div_max;
   logic       tick;

   // ==========================================================
   // Video edge copy, in phase with device
   assign div_max = 4'((5'h1 << ((video_clock_div_sel > pix_pkg::DIV_SEL_MAX) ?
                    pix_pkg::DIV_SEL_MAX : video_clock_div_sel)) - 5'h1);
   assign tick    = (div_cnt_r >= div_max);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= tick ? 4'h0 : div_cnt_r + 4'h1;
      end
   end

   // ==========================================================
   // Loads and flush
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flush_cnt_r      <= '0;
         px.pix_data      <= '0;
         px.load_enable_n <= 1'b1;
      end else if (flush_cnt_r != 3'h0) begin
         flush_cnt_r      <= flush_cnt_r - 3'h1;
         px.pix_data      <= '0;
         px.load_enable_n <= 1'b0;
      end else if (flush_req) begin
         // R17 dummy loads push last word
         case (port_width)
            pix_pkg::PW_16: flush_cnt_r <= pix_pkg::FLUSH_16 - 3'h1;
            pix_pkg::PW_32: flush_cnt_r <= pix_pkg::FLUSH_32 - 3'h1;
            default:        flush_cnt_r <= pix_pkg::FLUSH_64 - 3'h1;
         endcase
         px.pix_data      <= '0;
         px.load_enable_n <= 1'b0;
      end else begin
         px.pix_data      <= src_data;
         px.load_enable_n <= ~src_valid;
      end
   end

   // ==========================================================
   // Flyback sequence, one level per video edge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= HS_IDLE;
      end else if (tick) begin
         case (state_r)
            HS_IDLE: state_r <= flyback_req ? HS_LOW1 : HS_IDLE;
            HS_LOW1: state_r <= HS_HIGH;
            HS_HIGH: state_r <= HS_LOW2;
            HS_LOW2: state_r <= HS_IDLE;
            default: state_r <= HS_IDLE;
         endcase
      end else if (flyback_req && state_r == HS_IDLE) begin
         state_r <= HS_LOW1;
      end
   end

   // R14 device sees 0,1,0 on edges
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         px.blank_n <= pix_pkg::BLANK_N_RST;
         busy       <= 1'b0;
      end else begin
         busy <= (state_r != HS_IDLE) || (flush_cnt_r != 3'h0) || flush_req || flyback_req;
         case (state_r)
            HS_LOW1: px.blank_n <= 1'b0;
            HS_HIGH: px.blank_n <= 1'b1;
            HS_LOW2: px.blank_n <= 1'b0;
            default: px.blank_n <= src_blank_n;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== tb/pixel_port_unpack_fifo_monitor.sv
// Concurrent checks on the wire and outputs of the pixel port pair
`timescale 1ns/1ps
`default_nettype none
module pixel_port_unpack_fifo_monitor (
   // Clock and reset
   input wire logic                 sys_clk,
   input wire logic                 rst_b,
   // Wire between the ends
   input wire logic [63:0]          pix_data,
   input wire logic                 load_enable_n,
   input wire logic                 blank_n,
   // Configuration and requests
   input wire pix_pkg::port_width_e port_width,
   input wire pix_pkg::visual_e     visual,
   input wire logic                 pixel_mixing,
   input wire logic [2:0]           video_clock_div_sel,
   input wire logic [63:0]          src_data,
   input wire logic                 src_valid,
   input wire logic                 flush_req,
   // Device outputs
   input wire logic [9:0]           dac_red,
   input wire logic [9:0]           dac_green,
   input wire logic [9:0]           dac_blue,
   input wire logic                 dac_on,
   input wire logic                 lut_power,
   input wire logic                 frame_flyback,
   input wire logic [10:0]          cursor_x
);
   // ==========================================================
   // Clocking
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Flyback, judged at undivided video clock
   flyback_detect_a: assert property (
      (video_clock_div_sel == 3'h0 && !blank_n) ##1 blank_n ##1 !blank_n |=> frame_flyback)
      else $error("flyback pattern not flagged");
   flyback_pulse_a: assert property (frame_flyback |=> !frame_flyback)
      else $error("flyback flag longer than one cycle");
   flyback_clear_a: assert property (frame_flyback |-> cursor_x == 11'h000)
      else $error("cursor not cleared at flyback");

   // ==========================================================
   // Blanking and LUT power
   dac_dark_a: assert property (!dac_on |-> {dac_red, dac_green, dac_blue} == 30'h0)
      else $error("dac codes while off");
   blank_off_a: assert property ((video_clock_div_sel == 3'h0 && !blank_n)[*6] |-> !dac_on)
      else $error("dac still on after blanking");
   lut_off_a: assert property ((visual[1] && !pixel_mixing)[*2] |-> !lut_power)
      else $error("lut powered without mixing");
   lut_on_a: assert property ((pixel_mixing || !visual[1])[*2] |-> lut_power)
      else $error("lut unpowered while needed");

   // ==========================================================
   // Loads and flush counts
   load_follow_a: assert property (
      src_valid |=> !load_enable_n && pix_data == $past(src_data))
      else $error("load not driven after request");
   flush_16_a: assert property (flush_req && port_width == pix_pkg::PW_16
      |=> (!load_enable_n && pix_data == 64'h0)[*5] ##1 load_enable_n)
      else $error("flush length wrong on 16-bit port");
   flush_32_a: assert property (flush_req && port_width == pix_pkg::PW_32
      |=> (!load_enable_n && pix_data == 64'h0)[*3] ##1 load_enable_n)
      else $error("flush length wrong on 32-bit port");
   flush_64_a: assert property (flush_req && port_width == pix_pkg::PW_64
      |=> (!load_enable_n && pix_data == 64'h0)[*2] ##1 load_enable_n)
      else $error("flush length wrong on 64-bit port");
endmodule
`default_nettype wire

// ===== tb/pixel_port_unpack_fifo_tb_top.sv
// Bench joining host and device ends of the pixel port
`timescale 1ns/1ps
`default_nettype none
module pixel_port_unpack_fifo_tb_top;
   // ==========================================================
   // Stimulus and observed signals
   logic                 sys_clk      = 1'h0;
   logic                 rst_b        = 1'h0;
   pix_pkg::port_width_e port_width   = pix_pkg::PW_32;
   pix_pkg::visual_e     visual       = pix_pkg::VIS_16;
   logic                 pixel_mixing = 1'h1;
   logic                 direct_color = 1'h1;
   logic [2:0]           video_clock_div_sel = 3'h0;
   logic                 flyback_ctrl = 1'h0;
   logic                 lut_wr       = 1'h0;
   logic [7:0]           lut_wr_addr  = 8'h00;
   logic [23:0]          lut_wr_data  = 24'h000000;
   logic [63:0]          src_data     = 64'h0;
   logic                 src_valid    = 1'h0;
   logic                 src_blank_n  = 1'h0;
   logic                 flush_req    = 1'h0;
   logic                 flyback_req  = 1'h0;
   logic                 watch        = 1'h0;
   logic [9:0]           dac_red, dac_green, dac_blue;
   logic                 dac_on, lut_power, frame_flyback, fifo_overrun, busy;
   logic [10:0]          cursor_x;
   integer               seed         = 32'h6923;
   int                   n_fail       = 0;
   int                   n_tests      = 0;
   logic [23:0]          lut [256];
   logic [29:0]          exp_q [$];
   // modes, all widths, below 135 MHz
   logic [5:0]           cfg [8] = '{6'h27, 6'h21, 6'h33, 6'h3A, 6'h1A, 6'h13, 6'h06, 6'h01};

   always #25 sys_clk = ~sys_clk;

   pix_if px ();
   pix_port_host i_pix_port_host (.sys_clk, .rst_b, .px(px.host), .port_width, .video_clock_div_sel,
      .src_data, .src_valid, .src_blank_n, .flush_req, .flyback_req, .busy);
   pix_port_device i_pix_port_device (.sys_clk, .rst_b, .px(px.device), .port_width, .visual,
      .pixel_mixing, .direct_color, .video_clock_div_sel, .flyback_ctrl, .lut_wr, .lut_wr_addr,
      .lut_wr_data, .dac_red, .dac_green, .dac_blue, .dac_on, .lut_power, .frame_flyback,
      .cursor_x, .fifo_overrun);
   pixel_port_unpack_fifo_monitor i_pixel_port_unpack_fifo_monitor (.sys_clk, .rst_b,
      .pix_data(px.pix_data), .load_enable_n(px.load_enable_n), .blank_n(px.blank_n),
      .port_width, .visual, .pixel_mixing, .video_clock_div_sel, .src_data, .src_valid, .flush_req,
      .dac_red, .dac_green, .dac_blue, .dac_on, .lut_power, .frame_flyback, .cursor_x);

   // ==========================================================
   // Checking and verdict
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %0h seen %0h", what, e, s);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // About fifteen times the expected run length
   initial begin
      #2000000;
      n_fail++;
      conclude();
   end

   // Watched only in display windows
   always @(negedge sys_clk) begin
      if (watch && dac_on === 1'h1 && exp_q.size() == 0) chk("dac idle", 0, 1);
      else if (watch && dac_on === 1'h1) chk("dac", exp_q.pop_front(), {dac_red, dac_green, dac_blue});
   end

   // ==========================================================
   // Expected pixels
   // LUT byte widens to code
   function automatic logic [9:0] wid8(input logic [7:0] b);
      return {b, b[7:6]};
   endfunction

   function automatic logic [7:0] adr5(input logic [4:0] c);
      return {c, c[4:2]};
   endfunction

   function automatic logic [29:0] expect_px(input logic [31:0] p);
      if (visual == pix_pkg::VIS_16 && (!pixel_mixing || p[15]))
         return {p[14:10], p[14:10], p[9:5], p[9:5], p[4:0], p[4:0]};
      if (visual == pix_pkg::VIS_32 && (!pixel_mixing || p[31])) return p[29:0];
      if (direct_color && visual == pix_pkg::VIS_16)
         return {wid8(lut[adr5(p[14:10])][23:16]), wid8(lut[adr5(p[9:5])][15:8]),
                 wid8(lut[adr5(p[4:0])][7:0])};
      if (direct_color && visual == pix_pkg::VIS_32)
         return {wid8(lut[p[29:22]][23:16]), wid8(lut[p[19:12]][15:8]), wid8(lut[p[9:2]][7:0])};
      return {wid8(lut[p[7:0]][23:16]), wid8(lut[p[7:0]][15:8]), wid8(lut[p[7:0]][7:0])};
   endfunction

   task automatic note_word(input logic [127:0] w);
      logic [31:0] g;
      int          h;
      for (int k = 0; k < (128 >> (2 + visual)); k++) begin
         g = 32'(w >> ((4 << visual) * k));
         h = 32 * (k / 8) + 7 - k % 8;
         // plane 0 is index bit 0, p0 on top
         if (visual == pix_pkg::VIS_4) g = {28'h0, w[h + 24], w[h + 16], w[h + 8], w[h]};
         if (visual == pix_pkg::VIS_8) g[31:8] = 24'h0;
         if (visual == pix_pkg::VIS_16) g[31:16] = 16'h0;
         exp_q.push_back(expect_px(g));
      end
   endtask

   // ==========================================================
   // Drivers
   task automatic load_words(input int nw, input bit note);
      logic [63:0]  d;
      logic [127:0] w;
      int           nl;
      nl = 8 >> port_width;
      for (int i = 0; i < nw * nl; i++) begin
         d = {$random(seed), $random(seed)};
         if (d[40]) begin
            src_valid <= 1'h0;
            src_data <= ~d;
            @(posedge sys_clk);
         end
         d = d & ~(64'hFFFFFFFFFFFFFFFF << (16 << port_width));
         if (i % nl == 0) w = 128'h0;
         w = w | (128'(d) << ((16 << port_width) * (i % nl)));
         if (note && i % nl == nl - 1) note_word(w);
         src_data <= d;
         src_valid <= 1'h1;
         @(posedge sys_clk);
      end
      src_valid <= 1'h0;
      flush_req <= 1'h1;
      @(posedge sys_clk);
      flush_req <= 1'h0;
      @(posedge sys_clk);
      repeat (20) if (busy === 1'h1) @(posedge sys_clk);
   endtask

   task automatic flyback();
      flyback_req <= 1'h1;
      @(posedge sys_clk);
      flyback_req <= 1'h0;
      for (int k = 0; k < 300 && frame_flyback !== 1'h1; k++) @(negedge sys_clk);
      chk("flyback", 1, frame_flyback);
      chk("cursor", 0, cursor_x);
      repeat (100) if (busy === 1'h1) @(posedge sys_clk);
      @(posedge sys_clk);
   endtask

   task automatic run_mode(input logic [5:0] c);
      int n;
      visual <= pix_pkg::visual_e'(c[5:4]);
      port_width <= pix_pkg::port_width_e'(c[3:2]);
      pixel_mixing <= c[1];
      direct_color <= c[0];
      for (int a = 0; a < 256; a++) begin
         lut[a] = 24'($random(seed));
         lut_wr <= 1'h1;
         lut_wr_addr <= 8'(a);
         lut_wr_data <= lut[a];
         @(posedge sys_clk);
      end
      lut_wr <= 1'h0;
      chk("lut_power", {31'h0, ~(c[5] & ~c[1])}, lut_power);
      load_words(2, 1'h1);
      n = 2 * (128 >> (2 + c[5:4]));
      watch <= 1'h1;
      src_blank_n <= 1'h1;
      repeat (n) @(posedge sys_clk);
      src_blank_n <= 1'h0;
      repeat (12) @(posedge sys_clk);
      watch <= 1'h0;
      chk("pending", 0, exp_q.size());
      chk("cursor", n, cursor_x);
      flyback();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      chk("reset", 32'h3, {dac_on, frame_flyback, fifo_overrun, busy, cursor_x,
                           px.load_enable_n, px.blank_n});
      rst_b <= 1'h1;
      @(posedge sys_clk);
      for (int m = 0; m < 8; m++) run_mode(cfg[m]);
      // Seventeen words overrun sixteen
      port_width <= pix_pkg::PW_64;
      @(posedge sys_clk);
      load_words(17, 1'h0);
      repeat (5) @(posedge sys_clk);
      chk("overrun", 1, fifo_overrun);
      flyback_ctrl <= 1'h1;
      @(posedge sys_clk);
      flyback_ctrl <= 1'h0;
      repeat (3) @(posedge sys_clk);
      chk("overrun", 0, fifo_overrun);
      video_clock_div_sel <= 3'h2;
      @(posedge sys_clk);
      flyback();
      conclude();
   end
endmodule
`default_nettype wire
